// >>> hdl/nibble_core_consts.svh
// Purpose : named constants for the nibble core: opcodes, fields, reset values
// Assumes : 10-bit instruction words, 4-bit data path
// Notes   : wildcard opcode patterns are written in binary so that casez can use them
//
// How it works
// - xor with table nibble, carry from bit3
// - xor with immediate nibble from second word
// - increment accumulator, carry on wrap to zero
// - rotate left, old bit3 into bit0, carry
// - rotate, or internal reset when accumulator zero
// - port read into accumulator, carry cleared
// - port write latches accumulator until rewritten or reset
// - port and/or/xor write back, carry rules
// - byte immediate onto high and low port pair
// - register into accumulator, carry cleared
// - table nibble into accumulator, carry cleared
// - immediate nibble into accumulator, carry cleared
// - accumulator into register, carry kept
// - byte immediate into register pair n
// - table word into register pair 1..F
// - table address is page bits plus pair zero
// - jump loads ten scrambled address bits
// - conditional jump, else skip two words
// - 1K pages, only pages 0 and 1
// - two-cycle call, stack overflow forces reset
// - one-cycle return, stack underflow forces reset
// - timer and modulo nibble reads
`ifndef NIBBLE_CORE_CONSTS_SVH
`define NIBBLE_CORE_CONSTS_SVH
// reset values and steps
`define PC_RESET    11'h000
`define PC_STEP1    11'h001
`define PC_STEP2    11'h002
`define SP_RESET    3'h0
`define SP_TOP      3'h7
`define SP_STEP     3'h1
`define ACC_RESET   4'h0
`define NIB_ALL     4'hf
`define INC_ONE     5'h01
// instruction fields
`define F_GRP       9:6
`define F_BANK      5
`define F_REG       3:0
`define F_PORT      2:0
`define F_IMM4      3:0
`define F_IMM8      7:0
`define F_HI        7:4
`define F_LO        3:0
`define F_T_HI      9:6
`define F_T_LO      5:2
`define NIB_MSB     3
// scrambled jump target positions in the second word
`define JT_A9       9
`define JT_A8       4
`define JT_A7_4     8:5
`define JT_A3_0     3:0
// logic groups and port numbers
`define GRP_XOR     4'ha
`define GRP_AND     4'hd
`define PN0         3'h0
`define PN1         3'h1
`define PN3         3'h3
`define PN4         3'h4
`define SLOT0       2'h0
`define SLOT1       2'h1
`define SLOT3       2'h2
`define SLOT4       2'h3
`define REG_ZERO    4'h0
// opcodes
`define OP_XOR_REG  10'b1010?0????
`define OP_XOR_TBL  10'b1010?10000
`define OP_XOR_IMM  10'b1010110001
`define OP_XOR_PORT 10'b1010?11???
`define OP_AND_REG  10'b1101?0????
`define OP_AND_TBL  10'b1101?10000
`define OP_AND_IMM  10'b1101110001
`define OP_AND_PORT 10'b1101?11???
`define OP_OR_REG   10'b1110?0????
`define OP_OR_TBL   10'b1110?10000
`define OP_OR_IMM   10'b1110110001
`define OP_OR_PORT  10'b1110?11???
`define OP_INC      10'b1010010011
`define OP_RLZ      10'b1111010011
`define OP_RL       10'b1111110011
`define OP_MOV_A_T  10'b1111?11111
`define OP_MOV_A_M0 10'b1111?10110
`define OP_MOV_A_M1 10'b1111?10111
`define OP_IN       10'b1111?11???
`define OP_MOV_A_R  10'b1111?0????
`define OP_MOV_A_TB 10'b1111?10000
`define OP_MOV_A_IM 10'b1111110001
`define OP_OUT      10'b0010?11???
`define OP_MOV_R_A  10'b0010?0????
`define OP_OUT_BYTE 10'b0000110???
`define OP_PAIR_IMM 10'b000010????
`define OP_PAIR_TBL 10'b001110????
`define OP_JMP_P0   10'b0100010001
`define OP_JMP_P1   10'b0100110001
`define OP_JC_P0    10'b0110010001
`define OP_JC_P1    10'b0101010001
`define OP_JNC_P0   10'b0110110001
`define OP_JNC_P1   10'b0101110001
`define OP_JF_P0    10'b0111010001
`define OP_JF_P1    10'b1000010001
`define OP_JNF_P0   10'b0111110001
`define OP_JNF_P1   10'b1000110001
`define OP_CALL     10'b0011?10010
`define OP_RET      10'b0100010010
`endif

// >>> hdl/nibble_core_pkg.sv
// Purpose : types shared by the nibble core and its bench
// Assumes : nothing beyond the constants header
// Notes   : port slots 3..0 hold port numbers 4,3,1,0
package nibble_core_pkg;
  // one-hot execution state
  typedef enum logic [1:0] {
    ST_EXEC  = 2'h1,
    ST_CALL2 = 2'h2
  } core_state_t;
  // two groups of four nibble ports
  typedef struct packed {
    logic [3:0][3:0] hi;
    logic [3:0][3:0] lo;
  } port_bank_t;
  // timer and modulo registers as seen by the core
  typedef struct packed {
    logic [9:0] timer;
    logic [9:0] mod0;
    logic [9:0] mod1;
  } timer_view_t;
  // instruction word at pc and the word after it
  typedef struct packed {
    logic [9:0] word;
    logic [9:0] next_word;
  } fetch_t;
endpackage

// >>> hdl/nibble_core.sv
// Purpose : execution core of a 4-bit controller with 10-bit instructions
// Assumes : program memory answers both fetch words in the same cycle
// Notes   : two-word instructions other than call finish in one cycle; call takes two
`timescale 1ns/1ps
`include "nibble_core_consts.svh"
module nibble_core (
  // clock, reset, enable
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  // program memory fetch
  output logic [10:0]                    imem_addr_o,
  input  wire nibble_core_pkg::fetch_t   imem_fetch_i,
  // table access into program memory
  output logic [11:0]                    tbl_addr_o,
  input  wire logic [9:0]                tbl_word_i,
  input  wire logic [3:0]                rom_page_bits_control_i,
  // nibble ports
  input  wire nibble_core_pkg::port_bank_t port_in_i,
  output nibble_core_pkg::port_bank_t    port_out_o,
  // timer view and match flag source
  input  wire nibble_core_pkg::timer_view_t timer_view_i,
  input  wire logic                      match_load_i,
  input  wire logic                      match_value_i,
  // status
  output logic [3:0]                     acc_o,
  output logic                           carry_bit_o,
  output logic                           match_flag_o,
  output logic                           internal_reset_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  nibble_core_pkg::core_state_t state;   // execution phase
  logic [10:0] pc;                       // page bit and 10-bit address
  logic [3:0]  acc;                      // accumulator
  logic        carry_bit;                // carry flag
  logic        match_flag;               // status match flag
  logic [2:0]  sp;                       // stack pointer
  logic [10:0] return_address_save [8];  // return stack
  logic [3:0]  low_bank_register  [16];  // bank 0 nibbles
  logic [3:0]  high_bank_register [16];  // bank 1 nibbles

  // ------------------------------------------------------------
  // operand selection
  // ------------------------------------------------------------
  logic [9:0] ir;        // current instruction word
  logic [9:0] w2;        // second word
  logic [3:0] rd_reg;    // addressed nibble register
  logic [3:0] tbl_nib;   // selected table nibble
  logic [9:0] jump_addr; // unscrambled target
  logic [4:0] inc_sum;   // increment with carry out
  logic [1:0] slot;      // port slot
  logic       port_ok;   // port number is implemented
  logic [3:0] port_rd;   // selected port input
  logic [3:0] opnd;      // logic operand
  logic [3:0] lg_res;    // logic result
  logic       lg_cy;     // logic carry

  assign ir = imem_fetch_i.word;
  assign w2 = imem_fetch_i.next_word;
  assign rd_reg = ir[`F_BANK] ? high_bank_register[ir[`F_REG]] : low_bank_register[ir[`F_REG]];
  // the low form keeps bits 3..0, the high form 7..4; bits 9 and 8 are dropped
  assign tbl_nib = ir[`F_BANK] ? tbl_word_i[`F_LO] : tbl_word_i[`F_HI];
  // a9,a7..a4,a8,a3..a0 order in the second word
  assign jump_addr = {w2[`JT_A9], w2[`JT_A8], w2[`JT_A7_4], w2[`JT_A3_0]};
  assign inc_sum = {1'b0, acc} + `INC_ONE;
  // table address: page bits on top, register pair zero below
  assign tbl_addr_o = {rom_page_bits_control_i, high_bank_register[`REG_ZERO],
                       low_bank_register[`REG_ZERO]};

  // port number to slot; numbers 2,5,6,7 are not implemented
  always_comb begin
    port_ok = 1'b1;
    case (ir[`F_PORT])
      `PN0:    slot = `SLOT0;
      `PN1:    slot = `SLOT1;
      `PN3:    slot = `SLOT3;
      `PN4:    slot = `SLOT4;
      default: begin
        slot    = `SLOT0;
        port_ok = 1'b0;
      end
    endcase
  end

  // an unimplemented port reads as zero
  assign port_rd = !port_ok ? `ACC_RESET :
                   ir[`F_BANK] ? port_in_i.hi[slot] : port_in_i.lo[slot];

  // operand source for the and/or/xor family
  always_comb begin
    casez (ir)
      `OP_XOR_TBL, `OP_AND_TBL, `OP_OR_TBL:    opnd = tbl_nib;
      `OP_XOR_IMM, `OP_AND_IMM, `OP_OR_IMM:    opnd = w2[`F_IMM4];
      `OP_XOR_PORT, `OP_AND_PORT, `OP_OR_PORT: opnd = port_rd;
      default:                                 opnd = rd_reg;
    endcase
  end

  // and and xor carry acc3 & operand3; or clears carry
  always_comb begin
    case (ir[`F_GRP])
      `GRP_XOR: begin
        lg_res = acc ^ opnd;
        lg_cy  = acc[`NIB_MSB] & opnd[`NIB_MSB];
      end
      `GRP_AND: begin
        lg_res = acc & opnd;
        lg_cy  = acc[`NIB_MSB] & opnd[`NIB_MSB];
      end
      default: begin
        lg_res = acc | opnd;
        lg_cy  = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // execute
  // ------------------------------------------------------------
  logic [10:0] next_pc;    // program counter after this cycle
  logic [3:0]  next_acc;   // accumulator after this cycle
  logic        next_carry; // carry after this cycle
  logic        reg_we;     // accumulator into a register
  logic        pair_we;    // byte into a register pair
  logic [7:0]  pair_data;  // byte for the pair
  logic        port_we;    // accumulator into a port latch
  logic        byte_we;    // byte into a port pair
  logic        call_go;    // first call cycle
  logic        ret_go;     // return
  logic        soft_rst;   // internal reset request
  logic        is_br;      // two-word branch
  logic        br_take;    // branch condition holds
  logic        br_page;    // page of the target

  always_comb begin
    next_pc    = pc + `PC_STEP1;
    next_acc   = acc;
    next_carry = carry_bit;
    reg_we     = 1'b0;
    pair_we    = 1'b0;
    pair_data  = w2[`F_IMM8];
    port_we    = 1'b0;
    byte_we    = 1'b0;
    call_go    = 1'b0;
    ret_go     = 1'b0;
    soft_rst   = 1'b0;
    is_br      = 1'b0;
    br_take    = 1'b0;
    br_page    = ir[`F_BANK];
    if (state == nibble_core_pkg::ST_CALL2) begin
      // second call cycle: load the target
      next_pc = {br_page, jump_addr};
    end else begin
      casez (ir)
        // increment, carry only on wrap
        `OP_INC: begin
          next_acc   = inc_sum[3:0];
          next_carry = inc_sum[4];
        end
        // plain rotate
        `OP_RL: begin
          next_acc   = {acc[2:0], acc[`NIB_MSB]};
          next_carry = acc[`NIB_MSB];
        end
        // rotate, or reset the core on zero
        `OP_RLZ: begin
          soft_rst   = (acc == `ACC_RESET);
          next_acc   = {acc[2:0], acc[`NIB_MSB]};
          next_carry = acc[`NIB_MSB];
        end
        // immediate forms skip the data word
        `OP_XOR_IMM, `OP_AND_IMM, `OP_OR_IMM: begin
          next_acc   = lg_res;
          next_carry = lg_cy;
          next_pc    = pc + `PC_STEP2;
        end
        `OP_XOR_REG, `OP_AND_REG, `OP_OR_REG, `OP_XOR_TBL, `OP_AND_TBL, `OP_OR_TBL: begin
          next_acc   = lg_res;
          next_carry = lg_cy;
        end
        // timer reads sit before port reads: their codes overlap port 7
        `OP_MOV_A_T: begin
          next_acc = ir[`F_BANK] ? timer_view_i.timer[`F_T_HI] : timer_view_i.timer[`F_T_LO];
        end
        `OP_MOV_A_M0: begin
          next_acc   = ir[`F_BANK] ? timer_view_i.mod0[`F_T_HI] : timer_view_i.mod0[`F_T_LO];
          next_carry = 1'b0;
        end
        `OP_MOV_A_M1: begin
          next_acc   = ir[`F_BANK] ? timer_view_i.mod1[`F_T_HI] : timer_view_i.mod1[`F_T_LO];
          next_carry = 1'b0;
        end
        // port logic leaves state alone on a missing port
        `OP_XOR_PORT, `OP_AND_PORT, `OP_OR_PORT: begin
          if (port_ok) begin
            next_acc   = lg_res;
            next_carry = lg_cy;
          end
        end
        `OP_IN: begin
          next_acc   = port_rd;
          next_carry = 1'b0;
        end
        `OP_MOV_A_R: begin
          next_acc   = rd_reg;
          next_carry = 1'b0;
        end
        `OP_MOV_A_TB: begin
          next_acc   = tbl_nib;
          next_carry = 1'b0;
        end
        `OP_MOV_A_IM: begin
          next_acc   = w2[`F_IMM4];
          next_carry = 1'b0;
          next_pc    = pc + `PC_STEP2;
        end
        `OP_OUT:      port_we = port_ok;
        `OP_MOV_R_A:  reg_we  = 1'b1;
        `OP_OUT_BYTE: begin
          byte_we = port_ok;
          next_pc = pc + `PC_STEP2;
        end
        `OP_PAIR_IMM: begin
          pair_we = 1'b1;
          next_pc = pc + `PC_STEP2;
        end
        // pair zero is the pointer itself and is not a target
        `OP_PAIR_TBL: begin
          pair_we   = (ir[`F_REG] != `REG_ZERO);
          pair_data = tbl_word_i[`F_IMM8];
        end
        // page is fixed by the opcode; only pages 0 and 1 exist
        `OP_JMP_P0, `OP_JMP_P1: begin
          is_br   = 1'b1;
          br_take = 1'b1;
          br_page = (ir == `OP_JMP_P1);
        end
        `OP_JC_P0, `OP_JC_P1: begin
          is_br   = 1'b1;
          br_take = carry_bit;
          br_page = (ir == `OP_JC_P1);
        end
        `OP_JNC_P0, `OP_JNC_P1: begin
          is_br   = 1'b1;
          br_take = !carry_bit;
          br_page = (ir == `OP_JNC_P1);
        end
        `OP_JF_P0, `OP_JF_P1: begin
          is_br   = 1'b1;
          br_take = match_flag;
          br_page = (ir == `OP_JF_P1);
        end
        `OP_JNF_P0, `OP_JNF_P1: begin
          is_br   = 1'b1;
          br_take = !match_flag;
          br_page = (ir == `OP_JNF_P1);
        end
        // call holds pc for its second cycle
        `OP_CALL: begin
          call_go  = 1'b1;
          next_pc  = pc;
          soft_rst = (sp == `SP_TOP);
        end
        `OP_RET: begin
          ret_go   = 1'b1;
          next_pc  = return_address_save[sp];
          soft_rst = (sp == `SP_RESET);
        end
        default: ; // unknown codes act as no-op
      endcase
      if (is_br) begin
        next_pc = br_take ? {br_page, jump_addr} : pc + `PC_STEP2;
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // program flow; an internal reset acts like the pin reset
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc    <= `PC_RESET;
      sp    <= `SP_RESET;
      state <= nibble_core_pkg::ST_EXEC;
    end else if (ce_i) begin
      if (soft_rst) begin
        pc    <= `PC_RESET;
        sp    <= `SP_RESET;
        state <= nibble_core_pkg::ST_EXEC;
      end else begin
        pc    <= next_pc;
        state <= call_go ? nibble_core_pkg::ST_CALL2 : nibble_core_pkg::ST_EXEC;
        if (call_go) begin
          sp <= sp + `SP_STEP;
        end else if (ret_go) begin
          sp <= sp - `SP_STEP;
        end
      end
    end
  end

  // return stack: the return point is the word after the call
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && state == nibble_core_pkg::ST_CALL2) begin
      return_address_save[sp] <= pc + `PC_STEP2;
    end
  end

  // accumulator and flags
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc        <= `ACC_RESET;
      carry_bit  <= 1'b0;
      match_flag <= 1'b0;
    end else if (ce_i) begin
      if (soft_rst) begin
        acc        <= `ACC_RESET;
        carry_bit  <= 1'b0;
        match_flag <= 1'b0;
      end else begin
        acc       <= next_acc;
        carry_bit <= next_carry;
        if (match_load_i) begin
          match_flag <= match_value_i;
        end
      end
    end
  end

  // nibble registers keep their contents across resets
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && reg_we) begin
      if (ir[`F_BANK]) begin
        high_bank_register[ir[`F_REG]] <= acc;
      end else begin
        low_bank_register[ir[`F_REG]] <= acc;
      end
    end else if (ce_i && pair_we) begin
      high_bank_register[ir[`F_REG]] <= pair_data[`F_HI];
      low_bank_register[ir[`F_REG]]  <= pair_data[`F_LO];
    end
  end

  // port latches hold until written again or cleared by a pin or internal reset
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_out_o <= '0;
    end else if (ce_i) begin
      if (soft_rst) begin
        port_out_o <= '0;
      end else if (port_we) begin
        if (ir[`F_BANK]) begin
          port_out_o.hi[slot] <= acc;
        end else begin
          port_out_o.lo[slot] <= acc;
        end
      end else if (byte_we) begin
        port_out_o.hi[slot] <= w2[`F_HI];
        port_out_o.lo[slot] <= w2[`F_LO];
      end
    end
  end

  // one-cycle internal reset marker
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      internal_reset_o <= 1'b0;
    end else if (ce_i) begin
      internal_reset_o <= soft_rst;
    end
  end

  assign imem_addr_o  = pc;
  assign acc_o        = acc;
  assign carry_bit_o  = carry_bit;
  assign match_flag_o = match_flag;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  logic exec_now; // an instruction executes this edge
  assign exec_now = ce_i && state == nibble_core_pkg::ST_EXEC;

  sequence call_start_s;
    exec_now && (ir ==? `OP_CALL) && sp != `SP_TOP;
  endsequence
  sequence call_finish_s;
    ce_i && state == nibble_core_pkg::ST_CALL2;
  endsequence

  chk_inc_wrap: assert property (exec_now && (ir ==? `OP_INC) |=>
    acc == 4'($past(acc) + `INC_ONE) && carry_bit == ($past(acc) == `NIB_ALL))
    else $error("increment result or carry wrong");
  chk_rotate_left: assert property (exec_now && (ir ==? `OP_RL) |=>
    acc == {$past(acc[2:0]), $past(acc[3])} && carry_bit == $past(acc[3]))
    else $error("rotate result or carry wrong");
  chk_rlz_reset: assert property (exec_now && (ir ==? `OP_RLZ) && acc == `ACC_RESET |=>
    internal_reset_o && pc == `PC_RESET && sp == `SP_RESET)
    else $error("zero rotate did not reset");
  chk_port_hold: assert property (!(ce_i && (port_we || byte_we || soft_rst)) |=>
    $stable(port_out_o))
    else $error("port latch changed without a write");
  chk_reg_read: assert property (exec_now && (ir ==? `OP_MOV_A_R) |=>
    acc == $past(rd_reg) && !carry_bit)
    else $error("register read wrong");
  chk_reg_store: assert property (exec_now && (ir ==? `OP_MOV_R_A) |=>
    $stable(carry_bit) && $stable(acc))
    else $error("register store touched flags");
  chk_cond_skip: assert property (exec_now && (((ir ==? `OP_JC_P0) && !carry_bit) ||
    ((ir ==? `OP_JNC_P0) && carry_bit)) |=>
    pc == 11'($past(pc) + `PC_STEP2))
    else $error("untaken branch did not skip two words");
  chk_call_two: assert property (call_start_s ##1 call_finish_s |=>
    pc == {$past(ir[`F_BANK]), $past(jump_addr)} && state == nibble_core_pkg::ST_EXEC)
    else $error("call did not load target on second cycle");
  chk_ret_restore: assert property (exec_now && ret_go && sp != `SP_RESET |=>
    pc == $past(return_address_save[sp]) && sp == 3'($past(sp) - `SP_STEP) && !internal_reset_o)
    else $error("return did not restore pc");
  chk_mod_read: assert property (exec_now && (ir ==? `OP_MOV_A_M1) && ir[`F_BANK] |=>
    acc == $past(timer_view_i.mod1[`F_T_HI]) && !carry_bit)
    else $error("modulo read wrong");

endmodule

// >>> dv/prog_mem_model.sv
// Purpose : program memory partner, answers fetch and table reads at once
// Assumes : combinational read; unwritten words hold the all-zero no-op
// Notes   : the bench fills mem directly before each reset
`timescale 1ns/1ps
module prog_mem_model (
  // fetch side
  input  wire logic [10:0]        imem_addr_i,
  output nibble_core_pkg::fetch_t imem_fetch_o,
  // table side
  input  wire logic [11:0]        tbl_addr_i,
  output logic [9:0]              tbl_word_o
);
  // ---------------------------------
  // storage of pages 0 and 1
  // ---------------------------------
  logic [9:0] mem [0:2047];  // 2K words
  // word at pc and the word after it, same cycle
  // one driver for the whole struct: word first, then the word after it
  assign imem_fetch_o = {mem[imem_addr_i], mem[imem_addr_i + 11'h001]};
  // the top page bit folds back: only two pages exist
  assign tbl_word_o = mem[tbl_addr_i[10:0]];
endmodule

// >>> dv/testbench.sv
// Purpose : self-checking bench for the nibble core
// Assumes : ce_i held high except while the freeze scenario drops it
// Notes   : each scenario loads a tiny program, resets, steps and checks
`timescale 1ns/1ps
module testbench;
  // ---------------------------------
  // signals
  // ---------------------------------
  logic                        ref_clk_i = 1'b0;
  logic                        rst_i     = 1'b1;
  logic [10:0]                 imem_addr_o;
  nibble_core_pkg::fetch_t     fetch;
  logic [11:0]                 tbl_addr_o;
  logic [9:0]                  tbl_word;
  logic [3:0]                  page_bits = 4'h0;
  nibble_core_pkg::port_bank_t port_in   = '0;
  nibble_core_pkg::port_bank_t port_out_o;
  nibble_core_pkg::timer_view_t tview    = '0;
  logic [3:0]                  acc_o;
  logic                        carry_o, match_o, ireset_o;
  logic                        ce        = 1'b1;  // clock enable to the core
  logic                        match_ld  = 1'b0;  // match flag load strobe, value 1
  int                          n_fail = 0, compares = 0, cycles = 0;
  // 25 ns clock
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  nibble_core nibble_core_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce),
    .imem_addr_o(imem_addr_o), .imem_fetch_i(fetch), .tbl_addr_o(tbl_addr_o),
    .tbl_word_i(tbl_word), .rom_page_bits_control_i(page_bits), .port_in_i(port_in),
    .port_out_o(port_out_o), .timer_view_i(tview), .match_load_i(match_ld),
    .match_value_i(match_ld), .acc_o(acc_o), .carry_bit_o(carry_o), .match_flag_o(match_o),
    .internal_reset_o(ireset_o));
  prog_mem_model prog_mem_model_inst (.imem_addr_i(imem_addr_o), .imem_fetch_o(fetch),
    .tbl_addr_i(tbl_addr_o), .tbl_word_o(tbl_word));
  // ---------------------------------
  // shared tasks
  // ---------------------------------
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // load words from address 0 upward, rest is no-op
  task automatic load(input logic [9:0] w [$]);
    foreach (prog_mem_model_inst.mem[i]) prog_mem_model_inst.mem[i] = 10'h000;
    foreach (w[i]) prog_mem_model_inst.mem[i] = w[i];
  endtask
  // reset held for three cycles, released on an edge
  task automatic boot();
    @(posedge ref_clk_i) rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
  endtask
  // let n clock edges pass, enabled or not, sample once settled
  task automatic run(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // ---------------------------------
  // scenarios
  // ---------------------------------
  task automatic s_acc();
    load('{10'h3f1, 10'h00f, 10'h293, 10'h2b1, 10'h008});
    boot();
    run(2);
    chk("inc acc", {8'h00, acc_o}, 12'h000);
    chk("inc carry", {11'h000, carry_o}, 12'h001);
    chk("inc pc", {1'b0, imem_addr_o}, 12'h003);
    run(1);
    chk("xor imm acc", {7'h00, acc_o, carry_o}, 12'h010);
  endtask
  task automatic s_rot();
    load('{10'h3f1, 10'h009, 10'h3f3, 10'h3f1, 10'h000, 10'h3d3});
    boot();
    run(2);
    chk("rotate", {7'h00, acc_o, carry_o}, 12'h007);
    run(2);
    chk("zero reset pulse", {11'h000, ireset_o}, 12'h001);
    chk("zero reset pc", {1'b0, imem_addr_o}, 12'h000);
  endtask
  task automatic s_port();
    load('{10'h3f1, 10'h00a, 10'h099, 10'h3fc, 10'h033, 10'h0c6, 10'h3ff});
    @(posedge ref_clk_i) port_in.hi[3] <= 4'h5;
    tview.timer <= 10'h2c4;
    boot();
    run(2);
    chk("out latch", {8'h00, port_out_o.lo[1]}, 12'h00a);
    run(1);
    chk("port read", {7'h00, acc_o, carry_o}, 12'h00a);
    run(1);
    chk("byte out", {port_out_o.hi[2], port_out_o.lo[2], port_out_o.lo[1]}, 12'hc6a);
    run(1);
    chk("timer high", {8'h00, acc_o}, 12'h00b);
  endtask
  task automatic s_branch();
    load('{10'h3f1, 10'h00f, 10'h293, 10'h1b1, 10'h3ff, 10'h191, 10'h0b5});
    boot();
    run(3);
    chk("no-carry skip", {1'b0, imem_addr_o}, 12'h005);
    run(1);
    chk("carry jump", {1'b0, imem_addr_o}, 12'h155);
  endtask
  task automatic s_call();
    load('{10'h0d2, 10'h020, 10'h112});
    prog_mem_model_inst.mem[16] = 10'h112;
    boot();
    run(1);
    chk("call first cycle", {1'b0, imem_addr_o}, 12'h000);
    run(1);
    chk("call target", {1'b0, imem_addr_o}, 12'h010);
    run(1);
    chk("return", {1'b0, imem_addr_o}, 12'h002);
    run(1);
    chk("underflow reset", {11'h000, ireset_o}, 12'h001);
  endtask
  task automatic s_table();
    load('{10'h020, 10'h005, 10'h3d0, 10'h2b0});
    prog_mem_model_inst.mem[261] = 10'h2a7;
    @(posedge ref_clk_i) page_bits <= 4'h1;
    boot();
    run(1);
    chk("table addr", tbl_addr_o, 12'h105);
    run(1);
    chk("table high", {7'h00, acc_o, carry_o}, 12'h014);
    run(1);
    chk("table xor", {7'h00, acc_o, carry_o}, 12'h01a);
  endtask
  // match flag load, enable freeze, then a jump on the held flag
  task automatic s_match();
    load('{10'h000, 10'h1d1, 10'h0b5});
    boot();
    match_ld <= 1'b1;
    @(posedge ref_clk_i) match_ld <= 1'b0;
    ce <= 1'b0;
    run(1);
    chk("match load", {11'h000, match_o}, 12'h001);
    chk("frozen pc", {1'b0, imem_addr_o}, 12'h001);
    @(posedge ref_clk_i) ce <= 1'b1;
    run(1);
    chk("match jump", {1'b0, imem_addr_o}, 12'h155);
  endtask
  // ---------------------------------
  // verdict and hang guard
  // ---------------------------------
  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ceiling well above the roughly sixty cycles the scenarios need
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    s_acc();
    s_rot();
    s_port();
    s_branch();
    s_call();
    s_table();
    s_match();
    report_and_stop();
  end
endmodule
